// file: shared/awd_pkg.sv
// Purpose: shared constants for the auxiliary watchdog timer
// Assumes: 25 MHz aclk, AXI4-Lite register access
// Notes: register constants are word indices; the byte address is four times the index
package awd_pkg;
   // register indices as printed; byte address is four times the index
   localparam logic [7:0] AWD_IDX_UNIT = 8'hF1;
   localparam logic [7:0] AWD_IDX_VAL = 8'hF2;
   localparam logic [7:0] AWD_IDX_CFG = 8'hF3;
   localparam logic [7:0] AWD_IDX_CTRL = 8'hF4;
   // extra registers: interrupt status, enable, clear
   localparam logic [7:0] AWD_IDX_ISTAT = 8'hF8;
   localparam logic [7:0] AWD_IDX_IEN = 8'hF9;
   localparam logic [7:0] AWD_IDX_ICLR = 8'hFA;
   localparam int AWD_ADDR_W = 12;
   // field positions
   localparam int AWD_UNIT_SEC_BIT = 7;
   localparam int AWD_CFG_GAME_BIT = 0;
   localparam int AWD_CFG_KBD_BIT = 1;
   localparam int AWD_CFG_MOUSE_BIT = 2;
   localparam int AWD_CFG_IRQ_LSB = 4;
   localparam int AWD_CTRL_STAT_BIT = 0;
   localparam int AWD_CTRL_FORCE_BIT = 2;
   localparam int AWD_CTRL_KBCEN_BIT = 3;
   // interrupt status bits
   localparam int AWD_EV_TIMEOUT = 0;
   localparam int AWD_EV_FORCED = 1;
   localparam int AWD_EV_W = 2;
   // reset value and the invalid irq number
   localparam logic [7:0] AWD_RST_REG = 8'h00;
   localparam logic [3:0] AWD_IRQ_INVALID = 4'h2;
   // timing
   localparam longint AWD_CLK_HZ = 25000000;
   localparam longint AWD_SEC_S = 1;
   localparam longint AWD_SEC_CYC = AWD_CLK_HZ * AWD_SEC_S;
   localparam int AWD_MIN_SECS = 60;
   localparam logic [5:0] AWD_MIN_LAST = 6'(AWD_MIN_SECS - 1);
   // axi response codes
   localparam logic [1:0] AWD_RESP_OKAY = 2'h0;
   localparam logic [1:0] AWD_RESP_SLVERR = 2'h2;
endpackage

// file: hdl/awd_tick.sv
// Purpose: one-second and one-minute tick prescaler
// Assumes: single clock domain
// Notes: restart realigns both ticks to a fresh unit boundary
`timescale 1ns/1ns
module awd_tick #(
   parameter longint SEC_CYCLES = awd_pkg::AWD_SEC_CYC
)
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // control
   input wire logic restart,
   // ticks
   output logic sec_tick,
   output logic min_tick
);
   import awd_pkg::*;
   logic [31:0] cyc_ff;
   logic [5:0] sec_ff;
   logic [31:0] cyc_last;
   assign cyc_last = 32'(SEC_CYCLES - 1);
   ////////////////////////////////////////////////////////////////////////////
   // cycle divider to seconds
   always_ff @(posedge aclk)
   begin
      if (!aresetn || restart)
      begin
         cyc_ff <= 32'h0;
         sec_tick <= 1'b0;
      end
      else if (cyc_ff == cyc_last)
      begin
         cyc_ff <= 32'h0;
         sec_tick <= 1'b1;
      end
      else
      begin
         cyc_ff <= cyc_ff + 32'h1;
         sec_tick <= 1'b0;
      end
   end
   // seconds divider to minutes
   always_ff @(posedge aclk)
   begin
      if (!aresetn || restart)
      begin
         sec_ff <= 6'h0;
         min_tick <= 1'b0;
      end
      else if (sec_tick && sec_ff == AWD_MIN_LAST)
      begin
         sec_ff <= 6'h0;
         min_tick <= 1'b1;
      end
      else
      begin
         if (sec_tick)
         begin
            sec_ff <= sec_ff + 6'h1;
         end
         min_tick <= 1'b0;
      end
   end
endmodule

// file: hdl/awd_edge.sv
// Purpose: rising edge to single pulse detector
// Assumes: input synchronous to aclk
// Notes: a level held high gives only one pulse
`timescale 1ns/1ns
module awd_edge (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // level in, pulse out
   input wire logic level_in,
   output logic rise_pulse
);
   logic prev_ff;
   // previous sample
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         prev_ff <= 1'b0;
      end
      else
      begin
         prev_ff <= level_in;
      end
   end
   assign rise_pulse = level_in & ~prev_ff;
endmodule

// file: hdl/awd_watchdog.sv
// Purpose: auxiliary watchdog timer with AXI4-Lite registers
// Assumes: 25 MHz aclk; all event inputs synchronous to aclk
// Notes: control register sits on the standby reset only
//
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
module awd_watchdog #(
   parameter longint SEC_CYCLES = awd_pkg::AWD_SEC_CYC
)
(
   // clock and resets
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic host_reset,
   input wire logic standby_por_n,
   // axi write address
   input wire logic [awd_pkg::AWD_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi read address
   input wire logic [awd_pkg::AWD_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // reload and force sources
   input wire logic game_port_access,
   input wire logic kbd_irq,
   input wire logic mouse_irq,
   input wire logic kbc_reset_output,
   // outputs
   output logic [15:0] irq_lines,
   output logic irq
);
   import awd_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [7:0] addr_idx(input logic [AWD_ADDR_W-1:0] a);
      addr_idx = a[9:2];
   endfunction
   function automatic logic idx_ok(input logic [AWD_ADDR_W-1:0] a);
      logic [7:0] i;
      i = addr_idx(a);
      idx_ok = (a[AWD_ADDR_W-1:10] == 2'h0) && (a[1:0] == 2'h0) &&
               (i == AWD_IDX_UNIT || i == AWD_IDX_VAL || i == AWD_IDX_CFG ||
                i == AWD_IDX_CTRL || i == AWD_IDX_ISTAT || i == AWD_IDX_IEN ||
                i == AWD_IDX_ICLR);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic [7:0] unit_ff; // unit select
   logic [7:0] val_ff; // timeout value
   logic [7:0] cfg_ff; // reload and irq config
   logic kbcen_ff; // kbc reset force enable
   logic stat_ff; // timeout status
   logic [AWD_EV_W-1:0] istat_ff; // sticky events
   logic [AWD_EV_W-1:0] ien_ff; // event enables
   logic [7:0] cnt_ff; // units elapsed
   logic host_rst; // host-side reset
   logic aw_ff; // write address held
   logic w_ff; // write data held
   logic [AWD_ADDR_W-1:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic wr_go; // write performed this cycle
   logic [7:0] wr_idx;
   logic wr_ok;
   logic [7:0] wb; // low write byte
   logic wb_en;
   logic sec_tick;
   logic min_tick;
   logic unit_tick;
   logic kbc_rise;
   logic sw_force;
   logic forced;
   logic expire;
   logic timeout_ev;
   logic reload;
   logic val_wr;

   assign host_rst = !aresetn || host_reset;

   ////////////////////////////////////////////////////////////////////////////
   // axi write channel: address and data taken in either order
   assign s_axi_awready = !aw_ff && !s_axi_bvalid;
   assign s_axi_wready = !w_ff && !s_axi_bvalid;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_ff <= 1'b0;
         w_ff <= 1'b0;
         awaddr_ff <= '0;
         wdata_ff <= 32'h0;
         wstrb_ff <= 4'h0;
      end
      else if (wr_go)
      begin
         aw_ff <= 1'b0;
         w_ff <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
      end
   end
   assign wr_go = aw_ff && w_ff;
   assign wr_idx = addr_idx(awaddr_ff);
   assign wr_ok = idx_ok(awaddr_ff);
   assign wb = wdata_ff[7:0];
   assign wb_en = wr_go && wr_ok && wstrb_ff[0];
   assign val_wr = wb_en && wr_idx == AWD_IDX_VAL;
   // write response, error on unmapped address
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= AWD_RESP_OKAY;
      end
      else if (wr_go)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_ok ? AWD_RESP_OKAY : AWD_RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
         s_axi_bvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // host-reset configuration registers
   always_ff @(posedge aclk)
   begin
      if (host_rst)
      begin
         unit_ff <= AWD_RST_REG;
         val_ff <= AWD_RST_REG;
         cfg_ff <= AWD_RST_REG;
      end
      else if (wb_en)
      begin
         if (wr_idx == AWD_IDX_UNIT)
         begin
            unit_ff <= wb;
         end
         if (wr_idx == AWD_IDX_VAL)
         begin
            val_ff <= wb;
         end
         if (wr_idx == AWD_IDX_CFG)
         begin
            cfg_ff <= wb;
         end
      end
   end
   // control register, standby power-on reset only
   assign sw_force = wb_en && wr_idx == AWD_IDX_CTRL && wb[AWD_CTRL_FORCE_BIT];
   always_ff @(posedge aclk)
   begin
      if (!standby_por_n)
      begin
         kbcen_ff <= 1'b0;
         stat_ff <= 1'b0;
      end
      else
      begin
         if (wb_en && wr_idx == AWD_IDX_CTRL)
         begin
            kbcen_ff <= wb[AWD_CTRL_KBCEN_BIT];
         end
         if (timeout_ev)
         begin
            stat_ff <= 1'b1; // set wins over clear
         end
         else if (wb_en && wr_idx == AWD_IDX_CTRL)
         begin
            stat_ff <= wb[AWD_CTRL_STAT_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // ticks and force sources
   awd_tick #(
      .SEC_CYCLES(SEC_CYCLES)
   ) u_tick (
      .aclk(aclk),
      .aresetn(aresetn),
      .restart(reload),
      .sec_tick(sec_tick),
      .min_tick(min_tick)
   );
   awd_edge u_edge (
      .aclk(aclk),
      .aresetn(aresetn),
      .level_in(kbc_reset_output),
      .rise_pulse(kbc_rise)
   );
   assign unit_tick = unit_ff[AWD_UNIT_SEC_BIT] ? sec_tick : min_tick;
   assign forced = sw_force || (kbcen_ff && kbc_rise);
   assign reload = val_wr || host_rst
                   || (cfg_ff[AWD_CFG_GAME_BIT] && game_port_access)
                   || (cfg_ff[AWD_CFG_KBD_BIT] && kbd_irq)
                   || (cfg_ff[AWD_CFG_MOUSE_BIT] && mouse_irq);
   assign expire = val_ff != 8'h00 && !stat_ff && unit_tick && !reload &&
                   (cnt_ff + 8'h1) == val_ff;
   assign timeout_ev = expire || forced;

   ////////////////////////////////////////////////////////////////////////////
   // unit counter
   always_ff @(posedge aclk)
   begin
      if (reload || timeout_ev)
      begin
         cnt_ff <= 8'h00;
      end
      else if (unit_tick && val_ff != 8'h00 && !stat_ff)
      begin
         cnt_ff <= cnt_ff + 8'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // irq line mapping while status stands
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq_lines <= 16'h0000;
      end
      else
      begin
         irq_lines <= 16'h0000;
         if (stat_ff && cfg_ff[7:4] != 4'h0 && cfg_ff[7:4] != AWD_IRQ_INVALID)
         begin
            irq_lines[cfg_ff[7:4]] <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt status, enable, clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         istat_ff <= '0;
         ien_ff <= '0;
      end
      else
      begin
         if (wb_en && wr_idx == AWD_IDX_IEN)
         begin
            ien_ff <= wb[AWD_EV_W-1:0];
         end
         if (wb_en && wr_idx == AWD_IDX_ICLR)
         begin
            istat_ff <= istat_ff & ~wb[AWD_EV_W-1:0];
         end
         if (expire)
         begin
            istat_ff[AWD_EV_TIMEOUT] <= 1'b1;
         end
         if (forced)
         begin
            istat_ff[AWD_EV_FORCED] <= 1'b1;
         end
      end
   end
   assign irq = |(istat_ff & ien_ff);

   ////////////////////////////////////////////////////////////////////////////
   // axi read channel
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= AWD_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= idx_ok(s_axi_araddr) ? AWD_RESP_OKAY : AWD_RESP_SLVERR;
         s_axi_rdata <= 32'h0;
         if (idx_ok(s_axi_araddr))
         begin
            unique case (addr_idx(s_axi_araddr))
               AWD_IDX_UNIT: s_axi_rdata[7:0] <= unit_ff;
               AWD_IDX_VAL: s_axi_rdata[7:0] <= val_ff;
               AWD_IDX_CFG: s_axi_rdata[7:0] <= cfg_ff;
               AWD_IDX_CTRL: s_axi_rdata[7:0] <= {4'h0, kbcen_ff, 2'h0, stat_ff};
               AWD_IDX_ISTAT: s_axi_rdata[AWD_EV_W-1:0] <= istat_ff;
               AWD_IDX_IEN: s_axi_rdata[AWD_EV_W-1:0] <= ien_ff;
               default: s_axi_rdata <= 32'h0;
            endcase
         end
      end
      else if (s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// file: verif/awd_watchdog_sva.sv
// Purpose: port checks for the auxiliary watchdog
// Assumes: one aclk domain, bus masters keep ready high
// Notes: bound into every awd_watchdog instance
`timescale 1ns/1ns
module awd_watchdog_sva (
   // clock and resets
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic host_reset,
   // bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // mapped interrupt lines
   input wire logic [15:0] irq_lines
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // write answer two cycles after both halves taken
   property p_b_lat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
   a_b_lat: assert property (p_b_lat) else $error("late write response");
   property p_b_drop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
   a_b_drop: assert property (p_b_drop) else $error("write response repeated");
   property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_r_lat: assert property (p_r_lat) else $error("late read data");
   property p_r_drop; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
   a_r_drop: assert property (p_r_drop) else $error("read data repeated");
   // no new write while a response is pending
   property p_refuse; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   a_refuse: assert property (p_refuse) else $error("write taken while busy");
   property p_one_line; $onehot0(irq_lines); endproperty
   a_one_line: assert property (p_one_line) else $error("several lines driven");
   property p_no_line; !irq_lines[0] && !irq_lines[2]; endproperty
   a_no_line: assert property (p_no_line) else $error("line 0 or 2 driven");
   // a driven line stays put without software action or host reset
   property p_line_hold;
      (|irq_lines) && !s_axi_wvalid && !$past(s_axi_wvalid) && !s_axi_bvalid && !host_reset && !$past(host_reset)
      |=> irq_lines == $past(irq_lines);
   endproperty
   a_line_hold: assert property (p_line_hold) else $error("line changed alone");
   property p_host_rst; host_reset && !s_axi_wvalid |-> ##2 irq_lines == 16'h0000; endproperty
   a_host_rst: assert property (p_host_rst) else $error("map kept over host reset");
endmodule
bind awd_watchdog awd_watchdog_sva chk_u (.*);

// file: verif/awd_host_model.sv
// Purpose: host software and keyboard controller stand-in
// Assumes: response ready lines held high
// Notes: released address and data lines show the inverse
`timescale 1ns/1ns
module awd_host_model (
   // clock
   input wire logic aclk,
   // write side
   output logic [awd_pkg::AWD_ADDR_W-1:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   // read side
   output logic [awd_pkg::AWD_ADDR_W-1:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready,
   // event sources
   output logic game_port_access,
   output logic kbd_irq,
   output logic mouse_irq,
   output logic kbc_reset_output
);
   import awd_pkg::*;
   logic hung = 1'b0; // a bounded wait ran out
   initial
   begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_araddr, s_axi_arvalid} = '0;
      {game_port_access, kbd_irq, mouse_irq, kbc_reset_output} = '0;
      s_axi_bready = 1'b1;
      s_axi_rready = 1'b1;
   end
   // one write; reserved unit and control bits sent as zero
   task automatic wr(input logic [AWD_ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= (a[9:2] == AWD_IDX_UNIT) ? d & 32'h80 : (a[9:2] == AWD_IDX_CTRL) ? d & 32'h0D : d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (n = 0; n < 40; n++)
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready)
         begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~d;
         end
         if (s_axi_bvalid)
            break;
      end
      r = s_axi_bresp;
      if (n == 40)
         hung = 1'b1;
   endtask
   // one read
   task automatic rd(input logic [AWD_ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (n = 0; n < 40; n++)
      begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_arvalid <= 1'b0;
            s_axi_araddr <= ~a;
         end
         if (s_axi_rvalid)
            break;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      if (n == 40)
         hung = 1'b1;
   endtask
   // event levels: kbc reset, mouse, keyboard, game port
   task automatic set_ev(input logic [3:0] v);
      {kbc_reset_output, mouse_irq, kbd_irq, game_port_access} <= v;
   endtask
endmodule

// file: verif/awd_watchdog_bench.sv
// Purpose: self-checking bench for the auxiliary watchdog
// Assumes: a second shortened to SEC cycles
// Notes: expected register contents kept in mreg
`timescale 1ns/1ns
module awd_watchdog_bench;
   import awd_pkg::*;
   localparam longint SEC = 10;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic host_reset = 1'b0;
   logic standby_por_n = 1'b0;
   logic [AWD_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic game_port_access, kbd_irq, mouse_irq, kbc_reset_output, irq;
   logic [15:0] irq_lines;
   int fail_count = 0;
   int check_count = 0;
   int mreg [logic [7:0]]; // expected register words
   always #20 aclk = ~aclk;
   awd_watchdog #(.SEC_CYCLES(SEC)) dut_u (.*);
   awd_host_model h_u (.*);
   ////////////////////////////////////////
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      check_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t %s got %0h exp %0h", $time, m, got, exp);
      end
   endtask
   // a hung bus ends the run
   task automatic guard;
      if (h_u.hung)
      begin
         fail_count++;
         $display("[ERR] %0t bus wait ran out", $time);
         tally_and_finish();
      end
   endtask
   task automatic w(input logic [7:0] i, input logic [31:0] d);
      logic [1:0] r;
      h_u.wr({2'h0, i, 2'h0}, d, r);
      mreg[i] = d;
      guard();
      chk(r, AWD_RESP_OKAY, "bresp");
   endtask
   task automatic rx(input logic [7:0] i, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      h_u.rd({2'h0, i, 2'h0}, d, r);
      guard();
      chk(r, AWD_RESP_OKAY, "rresp");
      chk(d, e, "rdata");
   endtask
   // disable counting, clear status and events
   task automatic clr;
      w(AWD_IDX_VAL, 0);
      w(AWD_IDX_CTRL, 0);
      w(AWD_IDX_ICLR, 3);
   endtask
   task automatic wait_irq(input longint lim, output longint n);
      for (n = 0; n < lim && irq !== 1'b1; n++)
         @(posedge aclk);
   endtask
   ////////////////////////////////////////
   initial
   begin
      longint v;
      logic [31:0] d;
      logic [1:0] r;
      int maps[$];
      maps = '{0, 1, 2, 3, 15};
      void'($urandom(32'he2c5f2b5));
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      standby_por_n <= 1'b1;
      @(posedge aclk);
      for (int i = 8'hF1; i <= 8'hF4; i++) rx(8'(i), 0);
      rx(AWD_IDX_ISTAT, 0);
      h_u.rd(12'h3F0, d, r);
      chk({d[1:0], r}, AWD_RESP_SLVERR, "unmapped read");
      h_u.wr(12'h3F0, 32'hFF, r);
      chk(r, AWD_RESP_SLVERR, "unmapped write");
      w(AWD_IDX_UNIT, 32'($urandom_range(1)) << 7);
      w(AWD_IDX_CFG, $urandom & 32'hF7);
      rx(AWD_IDX_UNIT, mreg[AWD_IDX_UNIT]);
      rx(AWD_IDX_CFG, mreg[AWD_IDX_CFG]);
      $display("test registers done");
      w(AWD_IDX_IEN, 0);
      w(AWD_IDX_CTRL, 4);
      chk(irq, 0, "masked");
      w(AWD_IDX_IEN, 3);
      chk(irq, 1, "unmasked");
      clr();
      maps.push_back($urandom_range(15, 4));
      foreach (maps[k])
      begin
         w(AWD_IDX_CFG, maps[k] << 4);
         w(AWD_IDX_CTRL, 4);
         rx(AWD_IDX_CTRL, 1);
         rx(AWD_IDX_ISTAT, 2);
         chk(irq_lines, (maps[k] == 0 || maps[k] == 2) ? 0 : 1 << maps[k], "line map");
         clr();
         chk(irq_lines | irq, 0, "cleared");
      end
      $display("test irq map done");
      v = $urandom_range(5, 1);
      w(AWD_IDX_CFG, 32'h30);
      w(AWD_IDX_UNIT, 32'h80);
      w(AWD_IDX_VAL, 32'(v));
      mreg[8'h00] = 32'(v);
      wait_irq(v * SEC + 20, v);
      chk(v >= mreg[8'h00] * SEC - 2 && v <= mreg[8'h00] * SEC + 4, 1, "second count");
      rx(AWD_IDX_CTRL, 1);
      chk(irq_lines, 16'h0008, "line 3");
      clr();
      wait_irq(300, v);
      chk(v == 300, 1, "zero value");
      $display("test seconds done");
      for (int s = 0; s < 6; s++)
      begin
         w(AWD_IDX_CFG, (s & 1) << (s >> 1));
         w(AWD_IDX_VAL, 3);
         repeat (6)
         begin
            h_u.set_ev(4'(1 << (s >> 1)));
            @(posedge aclk);
            h_u.set_ev(4'h0);
            repeat ($urandom_range(7, 4)) @(posedge aclk);
         end
         // margin so an unreloaded count has surely expired
         repeat (4) @(posedge aclk);
         chk(irq, !(s & 1), "reload");
         clr();
      end
      $display("test reload done");
      h_u.set_ev(4'h8);
      repeat (40) @(posedge aclk);
      chk(irq, 0, "kbc ignored");
      h_u.set_ev(4'h0);
      w(AWD_IDX_CTRL, 8);
      h_u.set_ev(4'h8);
      repeat (40) @(posedge aclk);
      rx(AWD_IDX_CTRL, 9);
      w(AWD_IDX_CTRL, 8);
      w(AWD_IDX_ICLR, 3);
      repeat (10) @(posedge aclk);
      chk(irq, 0, "kbc one pulse");
      w(AWD_IDX_CTRL, 12);
      rx(AWD_IDX_CTRL, 9);
      h_u.set_ev(4'h0);
      clr();
      $display("test kbc done");
      w(AWD_IDX_UNIT, 0);
      w(AWD_IDX_VAL, 1);
      wait_irq(700, v);
      chk(v >= 60 * SEC - 2 && v <= 60 * SEC + 4, 1, "minute count");
      clr();
      w(AWD_IDX_UNIT, 32'h80);
      w(AWD_IDX_CFG, 32'h30);
      w(AWD_IDX_CTRL, 4);
      host_reset <= 1'b1;
      @(posedge aclk);
      host_reset <= 1'b0;
      @(posedge aclk);
      for (int i = 8'hF1; i <= 8'hF3; i++) rx(8'(i), 0);
      rx(AWD_IDX_CTRL, 1);
      clr();
      $display("test host reset done");
      tally_and_finish();
   end
endmodule
